// file: design/pbs_defines.svh
// constants for the pipelined burst sram model: widths, depths, field positions
// assumes inclusion by bare name from any file that needs them
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

`define PBS_ADDR_W 17
`define PBS_UPPER_W 15
`define PBS_DEPTH 131072
`define PBS_BYTES 4
`define PBS_DATA_W 36
`define PBS_PARITY_LSB 32
`define PBS_BUF_DEPTH 2
// buffer entry layout: {addr, mask, data}
`define PBS_BUF_W 89
`define PBS_BUF_DATA_LSB 0
`define PBS_BUF_MASK_LSB 36
`define PBS_BUF_ADDR_LSB 72
`define PBS_COUNT_RESET 2'h0

`endif

// file: design/pbs_pkg.sv
// types shared by the burst sram core and its write buffer
// assumes pbs_defines.svh is on the include path
`include "pbs_defines.svh"

package pbs_pkg;

  typedef enum logic [1:0] {
    PBS_OP_IDLE = 2'b00,
    PBS_OP_READ = 2'b01,
    PBS_OP_WRITE = 2'b10
  } pbs_op_t;

  typedef enum logic [1:0] {
    PBS_ST_DESELECT = 2'b00,
    PBS_ST_READ_BURST = 2'b01,
    PBS_ST_WRITE_BURST = 2'b10
  } pbs_state_t;

  typedef logic [`PBS_ADDR_W-1:0] pbs_addr_t;
  typedef logic [`PBS_DATA_W-1:0] pbs_word_t;
  typedef logic [`PBS_BUF_W-1:0] pbs_entry_t;

endpackage

// file: design/pbs_write_buffer.sv
// two-entry buffer holding write beats on their way into the array
// assumes one clock, async active-low reset; push and pop may share an edge
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_write_buffer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire pbs_pkg::pbs_entry_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output pbs_pkg::pbs_entry_t out_data
);
  import pbs_pkg::*;

  pbs_entry_t entry [`PBS_BUF_DEPTH];
  pbs_entry_t next_entry [`PBS_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = entry[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_entry = entry;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_entry[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    case ({push, pop})
      2'b10: next_count = count + 2'h1;
      2'b01: next_count = count - 2'h1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `PBS_BUF_DEPTH; i++) begin
        entry[i] <= '0;
      end
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      entry <= next_entry;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// file: design/pbs_sram.sv
// synchronous pipelined burst sram, bus side and storage
// assumes the controller runs on clk and drives every input synchronously to it
//
// What this block does
// - after a load, the two low address bits step through a four-word burst in the selected order.
// - a load edge ends any burst; a selected load takes new address and read/write control at that edge.
// - the read/write select is ignored while a burst advances.
// - every beat of a burst is read or write as captured at the loading edge.
// - a write starts when the chip is selected and read/write select and load/advance are both sampled low.
// - byte write enables lead their write data by one cycle and are paired that way.
// - an edge with the clock-gate enable sampled high is suppressed as though absent.
// - on a suppressed edge every internal register keeps its contents.
// - a chip select sampled inactive at a load edge starts a deselect cycle.
// - the data bus floats as the deselect slot reaches the bus, two active edges after the deselect edge.
// - a deselect does not cancel transfers already in the pipeline.
// - burst order is interleaved when the order input is high and linear when low.
// - the two-bit burst counter increments each advance within a read or write burst and wraps after the fourth beat.
// - each byte write enable gates its own byte and parity bit, in any combination.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_sram (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_gate_n,
  input wire logic [`PBS_UPPER_W-1:0] addr_upper,
  input wire logic burst_addr_bit_one,
  input wire logic burst_addr_bit_zero,
  input wire logic read_not_write,
  input wire logic load_or_advance_select,
  input wire logic chip_select_n,
  input wire logic chip_select_secondary,
  input wire logic chip_select_secondary_n,
  input wire logic burst_order,
  input wire logic [`PBS_BYTES-1:0] byte_write_enable_n,
  input wire pbs_pkg::pbs_word_t data_in,
  output pbs_pkg::pbs_word_t data_out,
  output logic data_oe
);
  import pbs_pkg::*;

  // byte i is data bits [8i+7:8i] plus parity bit 32+i
  function automatic pbs_word_t byte_mask(input logic [`PBS_BYTES-1:0] enable_n);
    pbs_word_t mask;
    mask = '0;
    for (int i = 0; i < `PBS_BYTES; i++) begin
      if (!enable_n[i]) begin
        mask[i*8 +: 8] = 8'hFF;
        mask[`PBS_PARITY_LSB + i] = 1'b1;
      end
    end
    return mask;
  endfunction

  function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] step,
                                           input logic interleaved);
    return interleaved ? (base ^ step) : 2'(base + step);
  endfunction

  pbs_word_t mem [`PBS_DEPTH];

  pbs_state_t state;
  pbs_addr_t base_addr;
  logic [1:0] burst_count;
  pbs_op_t s1_op;
  pbs_addr_t s1_addr;
  pbs_op_t s2_op;
  pbs_addr_t s2_addr;
  logic [`PBS_BYTES-1:0] s2_be_n;
  pbs_word_t rd_data;
  logic rd_drive;

  pbs_state_t next_state;
  pbs_addr_t next_base_addr;
  logic [1:0] next_burst_count;
  pbs_op_t next_s1_op;
  pbs_addr_t next_s1_addr;
  pbs_op_t next_s2_op;
  pbs_addr_t next_s2_addr;
  logic [`PBS_BYTES-1:0] next_s2_be_n;
  pbs_word_t next_rd_data;
  logic next_rd_drive;

  logic advance_edge;
  logic load;
  logic selected;
  logic [1:0] next_step;
  pbs_word_t stored;
  pbs_word_t head_mask;
  pbs_word_t head_data;
  pbs_addr_t head_addr;

  logic buf_in_valid;
  logic buf_in_ready;
  pbs_entry_t buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  pbs_entry_t buf_out_data;

  // a full buffer also holds the pipeline, so no write beat is ever dropped
  assign advance_edge = ~clk_gate_n & buf_in_ready;
  assign load = ~load_or_advance_select;
  assign selected = ~chip_select_n & chip_select_secondary & ~chip_select_secondary_n;
  assign next_step = burst_count + 2'h1;

  assign head_data = buf_out_data[`PBS_BUF_DATA_LSB +: `PBS_DATA_W];
  assign head_mask = buf_out_data[`PBS_BUF_MASK_LSB +: `PBS_DATA_W];
  assign head_addr = buf_out_data[`PBS_BUF_ADDR_LSB +: `PBS_ADDR_W];

  // array read with bypass of a write beat still sitting in the buffer head
  always_comb begin
    stored = mem[s2_addr];
    if (buf_out_valid && (head_addr == s2_addr)) begin
      stored = (stored & ~head_mask) | (head_data & head_mask);
    end
  end

  always_comb begin
    next_state = state;
    next_base_addr = base_addr;
    next_burst_count = burst_count;
    next_s1_op = PBS_OP_IDLE;
    next_s1_addr = s1_addr;
    if (load) begin
      next_burst_count = `PBS_COUNT_RESET;
      if (selected) begin
        next_base_addr = {addr_upper, burst_addr_bit_one, burst_addr_bit_zero};
        next_s1_addr = {addr_upper, burst_addr_bit_one, burst_addr_bit_zero};
        if (read_not_write) begin
          next_state = PBS_ST_READ_BURST;
          next_s1_op = PBS_OP_READ;
        end else begin
          next_state = PBS_ST_WRITE_BURST;
          next_s1_op = PBS_OP_WRITE;
        end
      end else begin
        next_state = PBS_ST_DESELECT;
        next_s1_op = PBS_OP_IDLE;
      end
    end else begin
      // read_not_write is not looked at here
      case (state)
        PBS_ST_READ_BURST: begin
          next_burst_count = next_step;
          next_s1_op = PBS_OP_READ;
          next_s1_addr = {base_addr[`PBS_ADDR_W-1:2],
                          burst_low(base_addr[1:0], next_step, burst_order)};
        end
        PBS_ST_WRITE_BURST: begin
          next_burst_count = next_step;
          next_s1_op = PBS_OP_WRITE;
          next_s1_addr = {base_addr[`PBS_ADDR_W-1:2],
                          burst_low(base_addr[1:0], next_step, burst_order)};
        end
        PBS_ST_DESELECT: begin
          next_s1_op = PBS_OP_IDLE;
        end
        default: begin
          next_state = PBS_ST_DESELECT;
          next_s1_op = PBS_OP_IDLE;
        end
      endcase
    end
    // ops already issued keep moving whatever the select pins do
    next_s2_op = s1_op;
    next_s2_addr = s1_addr;
    next_s2_be_n = byte_write_enable_n;
    next_rd_data = rd_data;
    next_rd_drive = 1'b0;
    if (s2_op == PBS_OP_READ) begin
      next_rd_data = stored;
      next_rd_drive = 1'b1;
    end
  end

  // write beat completes at the edge its data is sampled
  always_comb begin
    buf_in_valid = advance_edge & (s2_op == PBS_OP_WRITE);
    buf_in_data = '0;
    buf_in_data[`PBS_BUF_DATA_LSB +: `PBS_DATA_W] = data_in;
    buf_in_data[`PBS_BUF_MASK_LSB +: `PBS_DATA_W] = byte_mask(s2_be_n);
    buf_in_data[`PBS_BUF_ADDR_LSB +: `PBS_ADDR_W] = s2_addr;
  end

  // draining stalls on suppressed edges, like every other register
  assign buf_out_ready = ~clk_gate_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PBS_ST_DESELECT;
      base_addr <= '0;
      burst_count <= `PBS_COUNT_RESET;
      s1_op <= PBS_OP_IDLE;
      s1_addr <= '0;
      s2_op <= PBS_OP_IDLE;
      s2_addr <= '0;
      s2_be_n <= '1;
      rd_data <= '0;
      rd_drive <= 1'b0;
    end else if (advance_edge) begin
      state <= next_state;
      base_addr <= next_base_addr;
      burst_count <= next_burst_count;
      s1_op <= next_s1_op;
      s1_addr <= next_s1_addr;
      s2_op <= next_s2_op;
      s2_addr <= next_s2_addr;
      s2_be_n <= next_s2_be_n;
      rd_data <= next_rd_data;
      rd_drive <= next_rd_drive;
    end
  end

  // storage carries no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (buf_out_valid && buf_out_ready) begin
      mem[head_addr] <= (mem[head_addr] & ~head_mask) | (head_data & head_mask);
    end
  end

  assign data_out = rd_data;
  assign data_oe = rd_drive;

  pbs_write_buffer u_write_buffer (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

endmodule
`default_nettype wire

// file: testbench/pbs_sram_monitor.sv
// bus timing checker for pbs_sram, bound to the core
// assumes one clock; data slots land two active edges after their address edge
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_gate_n,
  input wire logic read_not_write,
  input wire logic load_or_advance_select,
  input wire logic chip_select_n,
  input wire logic chip_select_secondary,
  input wire logic chip_select_secondary_n,
  input wire pbs_pkg::pbs_word_t data_out,
  input wire logic data_oe
);
  import pbs_pkg::*;
  logic g, sel, ld, rd, wr, ds, adv;
  assign g = !clk_gate_n;
  assign sel = !chip_select_n && chip_select_secondary && !chip_select_secondary_n;
  assign ld = g && !load_or_advance_select;
  assign rd = ld && sel && read_not_write;
  assign wr = ld && sel && !read_not_write;
  assign ds = ld && !sel;
  assign adv = g && load_or_advance_select;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_on_bus: assert property (rd ##1 g ##1 g |=> data_oe)
    else $error("read slot not driven");
  a_write_bus_free: assert property (wr ##1 g ##1 g |=> !data_oe)
    else $error("write slot drove bus");
  a_gate_hold: assert property (!g |=> $stable(data_out) && $stable(data_oe))
    else $error("output moved on gated edge");
  a_deselect_float: assert property (ds ##1 g ##1 g |=> !data_oe)
    else $error("deselect slot driven");
  a_deselect_nop: assert property (ds ##1 adv ##1 g ##1 g |=> !data_oe)
    else $error("advance after deselect drove bus");
  a_read_burst_kind: assert property (rd ##1 (adv && !read_not_write) ##1 g ##1 g |=> data_oe)
    else $error("read burst beat lost");
  a_write_burst_kind: assert property (wr ##1 (adv && read_not_write) ##1 g ##1 g |=> !data_oe)
    else $error("write burst beat read");
  a_pending_read: assert property (rd ##1 ds ##1 g |=> data_oe)
    else $error("pending read cancelled");
endmodule
bind pbs_sram pbs_sram_monitor mon (.clk, .rst_b, .clk_gate_n, .read_not_write,
  .load_or_advance_select, .chip_select_n, .chip_select_secondary,
  .chip_select_secondary_n, .data_out, .data_oe);
`default_nettype wire

// file: testbench/pbs_ctrl_model.sv
// memory controller model: issues ops, pipelines byte enables and write data,
// shadows the array and queues expected read words; injects gated edges
`timescale 1ns/1ps
`default_nettype none
module pbs_ctrl_model (
  input wire logic clk,
  output logic clk_gate_n,
  output pbs_pkg::pbs_addr_t addr,
  output logic read_not_write,
  output logic load_or_advance_select,
  output logic [2:0] sel_bus,
  output logic burst_order,
  output logic [3:0] byte_write_enable_n,
  output pbs_pkg::pbs_word_t data_in
);
  import pbs_pkg::*;
  pbs_word_t mem [pbs_addr_t];
  pbs_word_t exp_q [$];
  pbs_word_t d1, d2, d;
  pbs_addr_t base, x;
  logic [1:0] step;
  logic [3:0] be1;
  logic w1 = 1'b0, w2 = 1'b0, kind, act = 1'b0;
  initial begin
    {clk_gate_n, load_or_advance_select, burst_order, sel_bus} = 6'h3D;
    {addr, read_not_write, byte_write_enable_n, data_in} = '0;
  end
  task automatic cyc(input logic av, input logic rnw, input logic s, input pbs_addr_t a,
                     input logic [3:0] be);
    @(negedge clk);
    if ($urandom_range(3) == 0) begin
      clk_gate_n = 1'b1;
      {addr, read_not_write, load_or_advance_select, sel_bus, byte_write_enable_n} = 26'($urandom);
      data_in = ~data_in;
      @(negedge clk);
    end
    d = pbs_word_t'({$urandom, $urandom});
    clk_gate_n = 1'b0;
    load_or_advance_select = av;
    addr = av ? pbs_addr_t'($urandom) : a;
    read_not_write = av ? 1'($urandom) : rnw;
    sel_bus = av ? 3'($urandom) : s ? 3'h2 : 3'h2 ^ (3'h1 << $urandom_range(2));
    if (!av) begin
      base = a;
      step = 2'h0;
      kind = rnw;
      act = s;
    end else begin
      step = step + 2'h1;
    end
    x = {base[16:2], burst_order ? base[1:0] ^ step : base[1:0] + step};
    byte_write_enable_n = w1 ? be1 : 4'($urandom);
    data_in = w2 ? d2 : ~data_in;
    {w2, d2, w1, be1, d1} = {w1, d1, act && !kind, be, d};
    for (int i = 0; i < 4; i++) begin
      if (act && !kind && !be[i]) begin
        mem[x][8*i+:8] = d[8*i+:8];
        mem[x][32+i] = d[32+i];
      end
    end
    if (act && kind) exp_q.push_back(mem[x]);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// top bench: clock, reset, scenarios through the controller model, read checker
// assumes pbs_sram returns read data two active edges after the address edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module tb;
  import pbs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_gate_n, read_not_write, load_or_advance_select, burst_order, data_oe, act;
  logic [2:0] sel_bus;
  logic [3:0] byte_write_enable_n;
  pbs_addr_t addr, b;
  pbs_word_t data_in, data_out, e_w;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  pbs_ctrl_model ctl (.clk, .clk_gate_n, .addr, .read_not_write, .load_or_advance_select,
    .sel_bus, .burst_order, .byte_write_enable_n, .data_in);
  pbs_sram dut (.clk, .rst_b, .clk_gate_n, .addr_upper(addr[16:2]),
    .burst_addr_bit_one(addr[1]), .burst_addr_bit_zero(addr[0]), .read_not_write,
    .load_or_advance_select, .chip_select_n(sel_bus[2]), .chip_select_secondary(sel_bus[1]),
    .chip_select_secondary_n(sel_bus[0]), .burst_order, .byte_write_enable_n, .data_in,
    .data_out, .data_oe);
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    act = !clk_gate_n && rst_b;
    #1;
    if (act && data_oe === 1'b1) begin
      e_w = ctl.exp_q.size() > 0 ? ctl.exp_q.pop_front() : 'x;
      `CHK(data_out, e_w)
    end
  end
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(32'hD597014E));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    for (int m = 0; m < 2; m++) begin
      ctl.burst_order = m[0];
      b = pbs_addr_t'($urandom);
      // five beats: the last wraps onto the base word
      ctl.cyc(1'b0, 1'b0, 1'b1, b, 4'h0);
      repeat (4) ctl.cyc(1'b1, 1'b0, 1'b1, b, 4'h0);
      ctl.cyc(1'b0, 1'b1, 1'b1, b, 4'h0);
      repeat (4) ctl.cyc(1'b1, 1'b1, 1'b1, b, 4'h0);
      for (int k = 0; k < 4; k++) ctl.cyc(1'b0, 1'b1, 1'b1, {b[16:2], 2'(k)}, 4'h0);
      $display("burst test order %0d done", m);
    end
    for (int i = 0; i < 8; i++) begin
      ctl.cyc(1'b0, 1'b0, 1'b1, b, i == 0 ? 4'hF : 4'($urandom));
      ctl.cyc(1'b0, 1'b1, 1'b1, b, 4'h0);
    end
    $display("byte write test done");
    // deselects right behind a read and a write must not cancel them
    ctl.cyc(1'b0, 1'b1, 1'b1, b, 4'h0);
    ctl.cyc(1'b0, 1'b0, 1'b0, b, 4'h0);
    ctl.cyc(1'b1, 1'b1, 1'b0, b, 4'h0);
    ctl.cyc(1'b0, 1'b0, 1'b1, b, 4'h0);
    ctl.cyc(1'b0, 1'b0, 1'b0, b, 4'h0);
    ctl.cyc(1'b0, 1'b1, 1'b1, b, 4'h0);
    repeat (4) ctl.cyc(1'b0, 1'b0, 1'b0, b, 4'h0);
    $display("deselect test done");
    `CHK(ctl.exp_q.size(), 0)
    summarize();
  end
endmodule
`default_nettype wire
